//--- adtc_control.sv
// Defrost scheduling, service test modes and power-on diagnosis.
// Assumes sensor codes come from a slow converter and are held stable.
//
// Behaviour
// - Freezer positions give -16 to -23 degrees
// - Fresh positions give 5 down to -1 degrees
// - Between positions: middle at diagnosis, else keep
// - First defrost after 4 h compressor run
// - Defrost heats, rests 10 min, holds loads
// - Heater enable by evaporator, ends at 17
// - Faulty evaporator sensor: rest only, no heat
// - First press: forced cooling, lamp 0.1 s
// - Forced cooling ends after 24 hours
// - Reset or second press ends forced cooling
// - Second press: forced defrost, lamp 0.5 s
// - Forced defrost heater off above 12, rest
// - Third press cancels, rests 10 min
// - Two second diagnosis before normal running
// - Fault keeps loads off until power cycle
// - Code pulses 0.3 s, 2 s gap
// - Several faults shown in priority order
// - Sensor open below -50, short above +50
// - Selector open at diagnosis stops; short forces high step
// - Compressor and heater never on together
`timescale 1ns/1ps
`default_nettype none
module adtc_control #(
  parameter int unsigned TICK_CYC = adtc_pkg::TICK_CYC
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic serviceBtn,
  input wire logic frzSelOpen,
  input wire logic frsSelOpen,
  input wire logic [7:0] frzSetpointSelector,
  input wire logic [7:0] frsSetpointSelector,
  input wire logic [7:0] frzEvaporatorSensor,
  input wire logic [7:0] frsEvaporatorSensor,
  input wire logic [7:0] frzCabinetSensor,
  input wire logic [7:0] frsCabinetSensor,
  output logic compOn,
  output logic frzFanOn,
  output logic frsFanOn,
  output logic frzHeatOn,
  output logic frsHeatOn,
  output logic boardLamp,
  output logic [7:0] frzSetpoint,
  output logic [7:0] frsSetpoint,
  output logic [5:0] faultFlags
);

  localparam int TW = adtc_pkg::TW;
  localparam int BW = adtc_pkg::BW;
  localparam int PW = $clog2(TICK_CYC);
  localparam int SW = 51;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers, all inputs in one two-stage vector
  logic [SW-1:0] syncA_r;
  logic [SW-1:0] syncB_r;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      syncA_r <= '0;
      syncB_r <= '0;
    end else begin
      syncA_r <= {serviceBtn, frzSelOpen, frsSelOpen,
                  frzSetpointSelector, frsSetpointSelector,
                  frzEvaporatorSensor, frsEvaporatorSensor,
                  frzCabinetSensor, frsCabinetSensor};
      syncB_r <= syncA_r;
    end
  end

  logic btnLvl;
  logic [1:0] selOpen;
  logic [7:0] selPos [2];
  adtc_pkg::adtc_temp_t temp [4];

  assign btnLvl = syncB_r[50];
  assign selOpen[0] = syncB_r[49];
  assign selOpen[1] = syncB_r[48];
  assign selPos[0] = syncB_r[47:40];
  assign selPos[1] = syncB_r[39:32];
  assign temp[adtc_pkg::F_FRZ_EVAP] = $signed(syncB_r[31:24]);
  assign temp[adtc_pkg::F_FRS_EVAP] = $signed(syncB_r[23:16]);
  assign temp[adtc_pkg::F_FRZ_CAB] = $signed(syncB_r[15:8]);
  assign temp[adtc_pkg::F_FRS_CAB] = $signed(syncB_r[7:0]);

  ////////////////////////////////////////////////////////////////////////////
  // Tick prescaler, the only time base
  logic [PW-1:0] pre_r;
  logic tick_r;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pre_r <= '0;
      tick_r <= 1'b0;
    end else if (pre_r == PW'(TICK_CYC - 1)) begin
      pre_r <= '0;
      tick_r <= 1'b1;
    end else begin
      pre_r <= pre_r + 1'b1;
      tick_r <= 1'b0;
    end
  end

  // Sampling the button once per tick also rides out contact bounce
  logic btnPrev_r;
  logic press;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      btnPrev_r <= 1'b0;
    end else if (tick_r) begin
      btnPrev_r <= btnLvl;
    end
  end

  assign press = tick_r && btnLvl && !btnPrev_r;

  ////////////////////////////////////////////////////////////////////////////
  // Sensor range checks
  logic [3:0] sensFault;

  for (genvar gi = 0; gi < 4; gi++) begin : g_sens
    assign sensFault[gi] = (temp[gi] < adtc_pkg::TEMP_OPEN) ||
                           (temp[gi] > adtc_pkg::TEMP_SHORT);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Selector decode and setting steps
  adtc_pkg::adtc_state_t state_r;
  adtc_pkg::adtc_state_t state_nxt;
  adtc_pkg::adtc_step_t settingStep_r [2];

  function automatic adtc_pkg::adtc_step_t onehot_idx(input logic [7:0] v);
    adtc_pkg::adtc_step_t r;
    r = '0;
    for (int k = 0; k < 8; k++) begin
      if (v[k]) begin
        r = 3'(k);
      end
    end
    return r;
  endfunction : onehot_idx

  for (genvar gi = 0; gi < 2; gi++) begin : g_sel
    logic isValid;
    logic isShort;

    assign isValid = ($countones(selPos[gi]) == 1) && !selOpen[gi];
    assign isShort = $countones(selPos[gi]) > 1;

    always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
        settingStep_r[gi] <= adtc_pkg::STEP_MID;
      end else if (isShort) begin
        settingStep_r[gi] <= adtc_pkg::STEP_HIGH;
      end else if (state_r == adtc_pkg::ST_DIAG) begin
        settingStep_r[gi] <= isValid ? onehot_idx(selPos[gi])
                                     : adtc_pkg::STEP_MID;
      end else if (isValid) begin
        settingStep_r[gi] <= onehot_idx(selPos[gi]);
      end
    end
  end

  adtc_pkg::adtc_temp_t frzSet_r;
  adtc_pkg::adtc_temp_t frsSet_r;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      frzSet_r <= adtc_pkg::FRZ_SET_TOP;
      frsSet_r <= adtc_pkg::frs_setpoint(adtc_pkg::STEP_MID);
    end else begin
      frzSet_r <= adtc_pkg::FRZ_SET_TOP -
                  $signed({4'h0, settingStep_r[0], 1'b0});
      frsSet_r <= adtc_pkg::frs_setpoint(settingStep_r[1]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode sequencing
  logic [TW-1:0] stTmr_r;
  logic [TW-1:0] stTmrInc;
  logic frzHeat_r;
  logic frsHeat_r;
  logic defReq_r;
  logic defBoth_r;
  logic diagFault;
  logic restDone;
  logic enterDef;
  logic enterFdef;

  assign stTmrInc = stTmr_r + 1'b1;
  assign diagFault = (|sensFault) || selOpen[0] || selOpen[1];
  assign restDone = tick_r && (stTmrInc == adtc_pkg::REST_TICKS);
  assign enterDef = (state_r == adtc_pkg::ST_NORMAL) &&
                    (state_nxt == adtc_pkg::ST_DEF_HEAT);
  assign enterFdef = (state_r == adtc_pkg::ST_FCOOL) &&
                     (state_nxt == adtc_pkg::ST_FDEF_HEAT);

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      adtc_pkg::ST_DIAG: begin
        if (tick_r && stTmrInc == adtc_pkg::DIAG_TICKS) begin
          state_nxt = diagFault ? adtc_pkg::ST_FAULT
                                : adtc_pkg::ST_NORMAL;
        end
      end
      adtc_pkg::ST_FAULT: begin
        state_nxt = adtc_pkg::ST_FAULT;
      end
      adtc_pkg::ST_NORMAL: begin
        if (press) begin
          state_nxt = adtc_pkg::ST_FCOOL;
        end else if (defReq_r) begin
          state_nxt = adtc_pkg::ST_DEF_HEAT;
        end
      end
      adtc_pkg::ST_DEF_HEAT: begin
        if (!frzHeat_r && !frsHeat_r) begin
          state_nxt = adtc_pkg::ST_DEF_REST;
        end
      end
      adtc_pkg::ST_DEF_REST: begin
        if (restDone) begin
          state_nxt = adtc_pkg::ST_NORMAL;
        end
      end
      adtc_pkg::ST_FCOOL: begin
        if (press) begin
          state_nxt = adtc_pkg::ST_FDEF_HEAT;
        end else if (tick_r && stTmrInc == adtc_pkg::FCOOL_TICKS) begin
          state_nxt = adtc_pkg::ST_NORMAL;
        end
      end
      adtc_pkg::ST_FDEF_HEAT: begin
        if (press) begin
          state_nxt = adtc_pkg::ST_FDEF_REST;
        end else if (!frzHeat_r && !frsHeat_r) begin
          state_nxt = adtc_pkg::ST_FDEF_REST;
        end
      end
      adtc_pkg::ST_FDEF_REST: begin
        if (restDone) begin
          state_nxt = adtc_pkg::ST_NORMAL;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_r <= adtc_pkg::ST_DIAG;
      stTmr_r <= '0;
    end else begin
      state_r <= state_nxt;
      if (state_nxt != state_r) begin
        stTmr_r <= '0;
      end else if (tick_r) begin
        stTmr_r <= stTmrInc;
      end
    end
  end

  // Faults are judged once, at the end of diagnosis
  logic [5:0] faults_r;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      faults_r <= '0;
    end else if (state_r == adtc_pkg::ST_DIAG && state_nxt != adtc_pkg::ST_DIAG) begin
      faults_r <= {selOpen[1], selOpen[0], sensFault};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Heater requests
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      frzHeat_r <= 1'b0;
      frsHeat_r <= 1'b0;
    end else if (enterDef) begin
      frzHeat_r <= defBoth_r && !sensFault[adtc_pkg::F_FRZ_EVAP] &&
                   (temp[adtc_pkg::F_FRZ_EVAP] < adtc_pkg::FRZ_HEAT_EN);
      frsHeat_r <= !sensFault[adtc_pkg::F_FRS_EVAP] &&
                   (temp[adtc_pkg::F_FRS_EVAP] < adtc_pkg::FRS_HEAT_EN);
    end else if (enterFdef) begin
      frzHeat_r <= !sensFault[adtc_pkg::F_FRZ_EVAP];
      frsHeat_r <= !sensFault[adtc_pkg::F_FRS_EVAP];
    end else if (state_r == adtc_pkg::ST_DEF_HEAT) begin
      if (sensFault[adtc_pkg::F_FRZ_EVAP] ||
          temp[adtc_pkg::F_FRZ_EVAP] >= adtc_pkg::HEAT_OFF) begin
        frzHeat_r <= 1'b0;
      end
      if (sensFault[adtc_pkg::F_FRS_EVAP] ||
          temp[adtc_pkg::F_FRS_EVAP] >= adtc_pkg::HEAT_OFF) begin
        frsHeat_r <= 1'b0;
      end
    end else if (state_r == adtc_pkg::ST_FDEF_HEAT) begin
      if (press || sensFault[adtc_pkg::F_FRZ_EVAP] ||
          temp[adtc_pkg::F_FRZ_EVAP] > adtc_pkg::FDEF_OFF) begin
        frzHeat_r <= 1'b0;
      end
      if (press || sensFault[adtc_pkg::F_FRS_EVAP] ||
          temp[adtc_pkg::F_FRS_EVAP] > adtc_pkg::FDEF_OFF) begin
        frsHeat_r <= 1'b0;
      end
    end else begin
      frzHeat_r <= 1'b0;
      frsHeat_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Run-time accumulation and defrost pattern: both, fresh, both, ...
  logic [TW-1:0] accum_r;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      accum_r <= '0;
      defReq_r <= 1'b0;
      defBoth_r <= 1'b1;
    end else begin
      if (enterDef) begin
        defReq_r <= 1'b0;
        defBoth_r <= !defBoth_r;
      end
      // Placed after the clear so a new request wins
      if (tick_r && compOn) begin
        if (accum_r + 1'b1 == adtc_pkg::DEF_RUN_TICKS) begin
          accum_r <= '0;
          defReq_r <= 1'b1;
        end else begin
          accum_r <= accum_r + 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Thermostat calls, frozen while an automatic defrost runs
  logic compCall_r;
  logic frsFanCall_r;
  logic regulate;
  logic holdLoads;

  assign regulate = (state_r == adtc_pkg::ST_NORMAL) || (state_r == adtc_pkg::ST_FCOOL);
  assign holdLoads = (state_r == adtc_pkg::ST_DEF_HEAT) ||
                     (state_r == adtc_pkg::ST_DEF_REST);

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      compCall_r <= 1'b0;
      frsFanCall_r <= 1'b0;
    end else if (regulate) begin
      if (temp[adtc_pkg::F_FRZ_CAB] > frzSet_r + adtc_pkg::HYST) begin
        compCall_r <= 1'b1;
      end else if (temp[adtc_pkg::F_FRZ_CAB] < frzSet_r - adtc_pkg::HYST) begin
        compCall_r <= 1'b0;
      end
      if (temp[adtc_pkg::F_FRS_CAB] > frsSet_r + adtc_pkg::HYST) begin
        frsFanCall_r <= 1'b1;
      end else if (temp[adtc_pkg::F_FRS_CAB] < frsSet_r - adtc_pkg::HYST) begin
        frsFanCall_r <= 1'b0;
      end
    end else if (!holdLoads) begin
      compCall_r <= 1'b0;
      frsFanCall_r <= 1'b0;
    end
  end

  logic compWant;

  assign compWant = (state_r == adtc_pkg::ST_FCOOL) ||
                    ((regulate || holdLoads) && compCall_r);

  ////////////////////////////////////////////////////////////////////////////
  // Load outputs; a heater waits one cycle for the compressor to drop
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      compOn <= 1'b0;
      frzFanOn <= 1'b0;
      frsFanOn <= 1'b0;
      frzHeatOn <= 1'b0;
      frsHeatOn <= 1'b0;
    end else begin
      compOn <= compWant && !frzHeat_r && !frsHeat_r;
      frzFanOn <= compWant;
      frsFanOn <= (regulate || holdLoads) && frsFanCall_r;
      frzHeatOn <= frzHeat_r && !compOn;
      frsHeatOn <= frsHeat_r && !compOn;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Board lamp
  logic [BW-1:0] lampDiv_r;
  logic lampT_r;
  logic lampAct;
  logic [BW-1:0] lampPer;
  logic blinkLamp;

  assign lampAct = (state_r == adtc_pkg::ST_FCOOL) ||
                   (state_r == adtc_pkg::ST_FDEF_HEAT) ||
                   (state_r == adtc_pkg::ST_FDEF_REST);
  assign lampPer = (state_r == adtc_pkg::ST_FCOOL) ? adtc_pkg::FC_BLINK_TICKS
                                                   : adtc_pkg::FD_BLINK_TICKS;

  always_ff @(posedge clk_sys) begin
    if (sys_rst || !lampAct) begin
      lampDiv_r <= '0;
      lampT_r <= 1'b0;
    end else if (tick_r) begin
      if (lampDiv_r + 1'b1 >= lampPer) begin
        lampDiv_r <= '0;
        lampT_r <= !lampT_r;
      end else begin
        lampDiv_r <= lampDiv_r + 1'b1;
      end
    end
  end

  adtc_fault_blink #(
    .NF(adtc_pkg::NFAULT)
  ) u_blink (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .tick(tick_r),
    .enable(state_r == adtc_pkg::ST_FAULT),
    .faults(faults_r),
    .lamp(blinkLamp)
  );

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      boardLamp <= 1'b0;
      frzSetpoint <= '0;
      frsSetpoint <= '0;
      faultFlags <= '0;
    end else begin
      boardLamp <= (state_r == adtc_pkg::ST_FAULT) ? blinkLamp : lampT_r;
      frzSetpoint <= frzSet_r;
      frsSetpoint <= frsSet_r;
      faultFlags <= faults_r;
    end
  end

endmodule : adtc_control
`default_nettype wire

//--- adtc_pkg.sv
// Constants, types and tables for the defrost and test controller.
// Assumes a 25 MHz system clock; temperatures are signed half-degree codes.
`default_nettype none
package adtc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clock and time base
  localparam int CLK_HZ = 25_000_000;
  localparam int TICK_MS = 100;
  localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
  localparam int TW = 20;
  localparam int BW = 5;

  // Times in their own units
  localparam int DIAG_MS = 2000;
  localparam int REST_MIN = 10;
  localparam int DEF_RUN_H = 4;
  localparam int FCOOL_H = 24;
  localparam int FC_BLINK_MS = 100;
  localparam int FD_BLINK_MS = 500;
  localparam int PULSE_MS = 300;
  localparam int GAP_MS = 2000;

  // Times as tick counts
  localparam logic [TW-1:0] DIAG_TICKS = TW'(DIAG_MS / TICK_MS);
  localparam logic [TW-1:0] REST_TICKS = TW'(REST_MIN * 60 * 1000 / TICK_MS);
  localparam logic [TW-1:0] DEF_RUN_TICKS = TW'(DEF_RUN_H * 3600 * 1000 / TICK_MS);
  localparam logic [TW-1:0] FCOOL_TICKS = TW'(FCOOL_H * 3600 * 1000 / TICK_MS);
  localparam logic [BW-1:0] FC_BLINK_TICKS = BW'(FC_BLINK_MS / TICK_MS);
  localparam logic [BW-1:0] FD_BLINK_TICKS = BW'(FD_BLINK_MS / TICK_MS);
  localparam logic [BW-1:0] PULSE_TICKS = BW'(PULSE_MS / TICK_MS);
  localparam logic [BW-1:0] GAP_TICKS = BW'(GAP_MS / TICK_MS);

  ////////////////////////////////////////////////////////////////////////////
  // Temperatures, 0.5 degree per LSB
  typedef logic signed [7:0] adtc_temp_t;
  localparam adtc_temp_t TEMP_OPEN = -8'sh64;
  localparam adtc_temp_t TEMP_SHORT = 8'sh64;
  localparam adtc_temp_t FRS_HEAT_EN = 8'sh14;
  localparam adtc_temp_t FRZ_HEAT_EN = -8'sh0A;
  localparam adtc_temp_t HEAT_OFF = 8'sh22;
  localparam adtc_temp_t FDEF_OFF = 8'sh18;
  localparam adtc_temp_t HYST = 8'sh02;
  localparam adtc_temp_t FRZ_SET_TOP = -8'sh20;

  // Setting steps, index 0 is position 1
  typedef logic [2:0] adtc_step_t;
  localparam adtc_step_t STEP_MID = 3'h3;
  localparam adtc_step_t STEP_HIGH = 3'h7;

  // Fault bit positions, also display priority
  localparam int F_FRZ_EVAP = 0;
  localparam int F_FRS_EVAP = 1;
  localparam int F_FRZ_CAB = 2;
  localparam int F_FRS_CAB = 3;
  localparam int F_FRZ_SEL = 4;
  localparam int F_FRS_SEL = 5;
  localparam int NFAULT = 6;

  typedef enum logic [2:0] {
    ST_DIAG, ST_FAULT, ST_NORMAL, ST_DEF_HEAT,
    ST_DEF_REST, ST_FCOOL, ST_FDEF_HEAT, ST_FDEF_REST
  } adtc_state_t;

  typedef enum logic [1:0] {BL_PICK, BL_ON, BL_OFF, BL_GAP} adtc_blink_t;

  function automatic adtc_temp_t frs_setpoint(input adtc_step_t s);
    adtc_temp_t r;
    r = -8'sh02;
    unique case (s)
      3'h0: r = 8'sh0A;
      3'h1: r = 8'sh08;
      3'h2: r = 8'sh06;
      3'h3: r = 8'sh04;
      3'h4: r = 8'sh02;
      3'h5: r = 8'sh00;
      default: r = -8'sh02;
    endcase
    return r;
  endfunction : frs_setpoint

endpackage : adtc_pkg
`default_nettype wire

//--- adtc_fault_blink.sv
// Blink-code generator for latched diagnosis faults.
// Assumes a one-cycle tick pulse every 100 ms from the parent.
`timescale 1ns/1ps
`default_nettype none
module adtc_fault_blink #(
  parameter int NF = adtc_pkg::NFAULT
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic tick,
  input wire logic enable,
  input wire logic [NF-1:0] faults,
  output logic lamp
);

  adtc_pkg::adtc_blink_t bst_r;
  logic [2:0] idx_r;
  logic [2:0] cnt_r;
  logic [adtc_pkg::BW-1:0] tmr_r;
  logic [adtc_pkg::BW-1:0] tmrInc;
  logic [2:0] idxNext;

  assign tmrInc = tmr_r + 1'b1;
  assign idxNext = (idx_r == 3'(NF - 1)) ? 3'h0 : idx_r + 3'h1;

  ////////////////////////////////////////////////////////////////////////////
  // Walk the faults in priority order, idx+1 pulses each
  always_ff @(posedge clk_sys) begin
    if (sys_rst || !enable) begin
      bst_r <= adtc_pkg::BL_PICK;
      idx_r <= 3'h0;
      cnt_r <= 3'h0;
      tmr_r <= '0;
      lamp <= 1'b0;
    end else begin
      unique case (bst_r)
        adtc_pkg::BL_PICK: begin
          if (faults[idx_r]) begin
            bst_r <= adtc_pkg::BL_ON;
            cnt_r <= 3'h0;
            tmr_r <= '0;
            lamp <= 1'b1;
          end else begin
            idx_r <= idxNext;
          end
        end
        adtc_pkg::BL_ON: begin
          if (tick) begin
            if (tmrInc == adtc_pkg::PULSE_TICKS) begin
              tmr_r <= '0;
              lamp <= 1'b0;
              bst_r <= adtc_pkg::BL_OFF;
            end else begin
              tmr_r <= tmrInc;
            end
          end
        end
        adtc_pkg::BL_OFF: begin
          if (tick) begin
            if (tmrInc == adtc_pkg::PULSE_TICKS) begin
              tmr_r <= '0;
              if (cnt_r == idx_r) begin
                bst_r <= adtc_pkg::BL_GAP;
              end else begin
                cnt_r <= cnt_r + 3'h1;
                lamp <= 1'b1;
                bst_r <= adtc_pkg::BL_ON;
              end
            end else begin
              tmr_r <= tmrInc;
            end
          end
        end
        adtc_pkg::BL_GAP: begin
          if (tick) begin
            if (tmrInc == adtc_pkg::GAP_TICKS) begin
              tmr_r <= '0;
              idx_r <= idxNext;
              bst_r <= adtc_pkg::BL_PICK;
            end else begin
              tmr_r <= tmrInc;
            end
          end
        end
      endcase
    end
  end

endmodule : adtc_fault_blink
`default_nettype wire

//--- adtc_control_properties.sv
// Port checker for the defrost and test controller.
// Assumes the bench holds sensor codes stable between changes.
`timescale 1ns/1ps
`default_nettype none
module adtc_control_properties #(
  parameter int unsigned TICK_CYC = adtc_pkg::TICK_CYC
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [7:0] frzSetpointSelector,
  input wire logic [7:0] frzEvaporatorSensor,
  input wire logic [7:0] frsEvaporatorSensor,
  input wire logic compOn,
  input wire logic frzFanOn,
  input wire logic frsFanOn,
  input wire logic frzHeatOn,
  input wire logic frsHeatOn,
  input wire logic boardLamp,
  input wire logic [7:0] frzSetpoint,
  input wire logic [7:0] frsSetpoint,
  input wire logic [5:0] faultFlags
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  logic [31:0] upCnt_r;
  logic anyLoad;
  assign anyLoad = compOn | frzFanOn | frsFanOn | frzHeatOn | frsHeatOn;
  // Saturates so a long run never wraps back into the diagnosis window
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      upCnt_r <= 32'h0;
    end else if (upCnt_r != 32'hFFFFFFFF) begin
      upCnt_r <= upCnt_r + 32'h1;
    end
  end
  ////////////////////////////////////////
  AST_INTERLOCK: assert property (!(compOn && (frzHeatOn || frsHeatOn)))
    else $error("compressor and heater on together");
  AST_RESET_OFF: assert property (disable iff (1'b0) sys_rst |=> !anyLoad && !boardLamp)
    else $error("loads on after reset");
  AST_DIAG_OFF: assert property (upCnt_r < 32'(adtc_pkg::DIAG_TICKS) * TICK_CYC |-> !anyLoad)
    else $error("load on during diagnosis");
  AST_FAULT_OFF: assert property (faultFlags != 6'h00 |-> !anyLoad)
    else $error("load on with a fault latched");
  AST_FRZ_SET: assert property (frzSetpoint != 8'h00 |->
    $signed(frzSetpoint) inside {[-46:-32]} && !frzSetpoint[0])
    else $error("freezer setpoint off table");
  AST_FRS_SET: assert property (frsSetpoint inside {8'h0A, 8'h08, 8'h06, 8'h04, 8'h02,
    8'h00, 8'hFE})
    else $error("fresh setpoint off table");
  AST_SHORT_HIGH: assert property (($countones(frzSetpointSelector) > 1)[*6] |->
    frzSetpoint == 8'hD2)
    else $error("shorted selector not at high step");
  AST_FRZ_HEAT_END: assert property (($signed(frzEvaporatorSensor) >= 34)[*5] |-> !frzHeatOn)
    else $error("freezer heater past end point");
  AST_FRS_HEAT_END: assert property (($signed(frsEvaporatorSensor) >= 34)[*5] |-> !frsHeatOn)
    else $error("fresh heater past end point");
  AST_OPEN_NO_HEAT: assert property (($signed(frzEvaporatorSensor) < -100)[*5] |-> !frzHeatOn)
    else $error("heater on with open probe");
  cover property (compOn && frzFanOn);
  cover property (frzHeatOn && frsHeatOn);
  cover property (faultFlags != 6'h00 && boardLamp);
endmodule : adtc_control_properties
bind adtc_control adtc_control_properties #(.TICK_CYC(TICK_CYC)) chk (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .frzSetpointSelector(frzSetpointSelector),
  .frzEvaporatorSensor(frzEvaporatorSensor), .frsEvaporatorSensor(frsEvaporatorSensor),
  .compOn(compOn), .frzFanOn(frzFanOn), .frsFanOn(frsFanOn), .frzHeatOn(frzHeatOn),
  .frsHeatOn(frsHeatOn), .boardLamp(boardLamp), .frzSetpoint(frzSetpoint),
  .frsSetpoint(frsSetpoint), .faultFlags(faultFlags));
`default_nettype wire

//--- adtc_plant.sv
// Evaporator probe model that warms under each heater.
// Assumes the controller's heater outputs; the bench can open the freezer probe.
`timescale 1ns/1ps
`default_nettype none
module adtc_plant (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic frzHeatOn,
  input wire logic frsHeatOn,
  input wire logic frzOpen,
  output logic [7:0] frzEvaporatorSensor,
  output logic [7:0] frsEvaporatorSensor
);
  logic [3:0] slow_r;
  logic [7:0] frzTemp_r;
  logic [7:0] frsTemp_r;
  // One step per 16 clocks, slower than the input synchronisers
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      slow_r <= 4'h0;
      frzTemp_r <= 8'hEC;
      frsTemp_r <= 8'h00;
    end else begin
      slow_r <= slow_r + 4'h1;
      if (slow_r == 4'hF && frzHeatOn) frzTemp_r <= frzTemp_r + 8'h01;
      if (slow_r == 4'hF && frsHeatOn) frsTemp_r <= frsTemp_r + 8'h01;
    end
  end
  ////////////////////////////////////////
  // Open probe reads far below the open threshold
  assign frzEvaporatorSensor = frzOpen ? 8'h80 : frzTemp_r;
  assign frsEvaporatorSensor = frsTemp_r;
endmodule : adtc_plant
`default_nettype wire

//--- testbench.sv
// Self-checking bench for the defrost and test controller.
// Assumes a short tick of 8 clocks and a plant model on the probes.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int unsigned TC = 8;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic serviceBtn = 1'b0;
  logic frsSelOpen = 1'b0;
  logic frzOpen = 1'b0;
  logic [7:0] frzSel = 8'h08;
  logic [7:0] frsSel = 8'h08;
  logic compOn, frzFanOn, frsFanOn, frzHeatOn, frsHeatOn, boardLamp, lamp0;
  logic [7:0] frzSetpoint, frsSetpoint, frzEvap, frsEvap;
  logic [5:0] faultFlags;
  int mismatches = 0;
  int tests_run = 0;
  int cycles = 0;
  int n;
  // Selectors in, setpoint codes out
  logic [31:0] rows [10] = '{32'h0180E0FE, 32'h0240DEFE, 32'h0420DC00, 32'h0810DA02,
    32'h0000DA02, 32'h03C0D2FE, 32'h1008D804, 32'h2004D606, 32'h4002D408, 32'h8001D20A};
  always #20 clk_sys = ~clk_sys;
  adtc_control #(.TICK_CYC(TC)) dut (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .serviceBtn(serviceBtn), .frzSelOpen(1'b0), .frsSelOpen(frsSelOpen),
    .frzSetpointSelector(frzSel), .frsSetpointSelector(frsSel),
    .frzEvaporatorSensor(frzEvap), .frsEvaporatorSensor(frsEvap),
    .frzCabinetSensor(8'h00), .frsCabinetSensor(8'h00), .compOn(compOn),
    .frzFanOn(frzFanOn), .frsFanOn(frsFanOn), .frzHeatOn(frzHeatOn), .frsHeatOn(frsHeatOn),
    .boardLamp(boardLamp), .frzSetpoint(frzSetpoint), .frsSetpoint(frsSetpoint),
    .faultFlags(faultFlags));
  adtc_plant plant (.clk_sys(clk_sys), .sys_rst(sys_rst), .frzHeatOn(frzHeatOn),
    .frsHeatOn(frsHeatOn), .frzOpen(frzOpen), .frzEvaporatorSensor(frzEvap),
    .frsEvaporatorSensor(frsEvap));
  ////////////////////////////////////////
  task automatic wait_cyc(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask : wait_cyc
  task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
      mismatches++;
    end
  endtask : check8
  task automatic press();
    serviceBtn = 1'b1;
    wait_cyc(3 * TC);
    serviceBtn = 1'b0;
    wait_cyc(3 * TC);
  endtask : press
  task automatic do_reset();
    sys_rst = 1'b1;
    wait_cyc(4);
    sys_rst = 1'b0;
    wait_cyc(25 * TC);
  endtask : do_reset
  task automatic wrap_up();
    $display("comparisons %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up
  // Ceiling well above the roughly 50000 cycles the sequence needs
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 70000) begin
      mismatches++;
      wrap_up();
    end
  end
  ////////////////////////////////////////
  initial begin
    do_reset();
    check8("faultFlags", 8'h00, {2'h0, faultFlags});
    for (int i = 0; i < 10; i++) begin
      frzSel = rows[i][31:24];
      frsSel = rows[i][23:16];
      wait_cyc(6);
      check8("frzSetpoint", rows[i][15:8], frzSetpoint);
      check8("frsSetpoint", rows[i][7:0], frsSetpoint);
    end
    $display("setpoint table done");
    press();
    check8("cooling loads", 8'h03, {6'h0, compOn, frzFanOn});
    lamp0 = boardLamp;
    wait_cyc(TC);
    check8("boardLamp", {7'h0, ~lamp0}, {7'h0, boardLamp});
    press();
    check8("defrost loads", 8'h03, {3'h0, compOn, frzFanOn, frsFanOn, frzHeatOn, frsHeatOn});
    n = 0;
    while ((frzHeatOn || frsHeatOn) && n < 2000) begin
      wait_cyc(1);
      n++;
    end
    check8("frsEvap", 8'h19, frsEvap);
    check8("frzEvap", 8'h19, frzEvap);
    wait_cyc((int'(adtc_pkg::REST_TICKS) - 10) * TC);
    check8("compOn in rest", 8'h00, {7'h0, compOn});
    wait_cyc(30 * TC);
    check8("compOn after rest", 8'h01, {7'h0, compOn});
    $display("forced modes done");
    frzOpen = 1'b1;
    frsSelOpen = 1'b1;
    do_reset();
    check8("faultFlags", 8'h21, {2'h0, faultFlags});
    press();
    check8("fault loads", 8'h00, {3'h0, compOn, frzFanOn, frsFanOn, frzHeatOn, frsHeatOn});
    lamp0 = boardLamp;
    wait_cyc(1);
    while (!(boardLamp && !lamp0)) begin
      lamp0 = boardLamp;
      wait_cyc(1);
    end
    n = 0;
    repeat (82 * TC + 4) begin
      lamp0 = boardLamp;
      wait_cyc(1);
      if (boardLamp && !lamp0) n++;
    end
    check8("lamp pulses", 8'h07, n[7:0]);
    $display("fault display done");
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
